/* File: vfm_pkg.sv */
// Register map, field layout, timing constants and shared types for the vout fault monitor
package vfm_pkg;
    // Command codes on the management bus
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OV_FAULT_THR = 8'h40;
    localparam logic [7:0] CMD_OV_FAULT_RESP = 8'h41;
    localparam logic [7:0] CMD_OV_WARN_THR = 8'h42;
    localparam logic [7:0] CMD_UV_WARN_THR = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT_THR = 8'h44;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;

    // Threshold limits, 2^-13 V per lsb
    localparam logic [15:0] OV_FAULT_MAX = 16'hc000;
    localparam logic [15:0] THR_MAX = 16'hb000;

    // Reset values
    localparam logic [15:0] OV_FAULT_RST = 16'h4ccd;
    localparam logic [15:0] OV_WARN_RST = 16'h228f;
    localparam logic [15:0] UV_WARN_RST = 16'h1c29;
    localparam logic [15:0] UV_FAULT_RST = 16'h0ccd;
    localparam logic [7:0] OV_RESP_RST = 8'hb8;

    // Fault response fields
    localparam int RESP_BEHAV_HI = 7;
    localparam int RESP_BEHAV_LO = 6;
    localparam int RESP_RETRY_HI = 5;
    localparam int RESP_RETRY_LO = 3;
    localparam int RESP_DELAY_HI = 2;
    localparam int RESP_DELAY_LO = 0;
    localparam logic [1:0] BEHAV_DISABLE_RETRY = 2'h2;
    localparam logic [2:0] RETRY_NONE = 3'h0;

    // Status bit positions
    localparam int SW_VOUT_BIT = 15;
    localparam int SW_OV_FAULT_BIT = 5;
    localparam int SV_OV_FAULT_BIT = 7;
    localparam int SV_OV_WARN_BIT = 6;
    localparam int SV_UV_WARN_BIT = 5;
    localparam int SV_UV_FAULT_BIT = 4;

    // Byte engine counts
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    localparam logic [2:0] CNT_CMD_ONLY = 3'h2;
    localparam logic [2:0] CNT_ONE_DATA = 3'h3;
    localparam logic [2:0] CNT_TWO_DATA = 3'h4;
    localparam logic [2:0] CNT_SAT = 3'h7;

    // Timing
    localparam int RETRY_STEP_MS = 35;
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_FREQ_KHZ;
    localparam int RETRY_CNT_W = 25;

    typedef struct packed {
        logic [15:0] ov_fault;
        logic [15:0] ov_warn;
        logic [15:0] uv_warn;
        logic [15:0] uv_fault;
    } vfm_thr_t;

    typedef struct packed {
        logic [15:0] vout;
        logic valid;
        logic power_good;
        logic ramping;
    } vfm_sense_t;

    typedef struct packed {
        logic enable_cmd;
        logic bias_ok;
        logic other_shutdown;
    } vfm_ctrl_t;

    typedef enum logic [1:0] {
        RUN_OFF = 2'h0,
        RUN_ON = 2'h1,
        RUN_WAIT = 2'h3,
        RUN_LATCH = 2'h2
    } vfm_run_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'h0,
        BUS_RX = 3'h1,
        BUS_RACK = 3'h3,
        BUS_TX = 3'h2,
        BUS_TACK = 3'h6
    } vfm_bus_t;
endpackage

/* File: vfm_sync.sv */
// Two flip-flop synchroniser for one pin input
module vfm_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic pin_in,
    output logic pin_sync
);
    import vfm_pkg::*;

    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else if (ce) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_sync = sync_r;
endmodule

/* File: vfm_retry_timer.sv */
// Down counter that times the gap between a fault and the next restart
module vfm_retry_timer #(
    parameter int CNT_W = 25
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_count,
    output logic expired
);
    import vfm_pkg::*;

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic expired_r;
    logic expired_nxt;

    if (CNT_W < 2) begin : g_chk
        $error("vfm_retry_timer: CNT_W too small");
    end

    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = load_count;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
        expired_nxt = ~load & (count_nxt == '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_r <= '0;
            expired_r <= 1'b1;
        end else if (ce) begin
            count_r <= count_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired = expired_r;
endmodule

/* File: vfm_top.sv */
// Output voltage fault monitor with management bus slave and overvoltage retry control
// Operation
// - Thresholds are unsigned 16-bit at 2^-13 V; overvoltage fault spans 0 to 6 V.
// - Out-of-range threshold writes are dropped, keeping the old value.
// - Overvoltage fault sets summary and overvoltage-fault bits and raises the alert.
// - Overvoltage warning sets summary and overvoltage-warning bits and raises the alert.
// - A fast rise through the warning level may leave no warning recorded.
// - Fault response register picks latch-off or endless retry.
// - Retry codes 001-111 keep retrying until off command, bias loss or other shutdown.
// - A retry starts only after the output falls below the warning threshold.
// - Retry spacing is (delay field plus one) times 35 ms.
// - Retry delay is timed from fault detection to each restart.
// - Undervoltage detection is masked while ramping, before power-good, or disabled.
// - Undervoltage fault sets summary and undervoltage-fault bits and raises the alert.
// - Behaviour code 10 disables the output then retries per the retry field.
module vfm_top
    import vfm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h20,
    parameter int RETRY_STEP = vfm_pkg::RETRY_STEP_CYCLES,
    parameter int CNT_W = vfm_pkg::RETRY_CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic alert_request_line_out,
    output logic alert_request_line_oe,
    input wire vfm_pkg::vfm_sense_t sense,
    input wire vfm_pkg::vfm_ctrl_t ctrl,
    output logic output_drive_en
);
    import vfm_pkg::*;

    if (RETRY_STEP < 1 || longint'(RETRY_STEP) * 8 >= (longint'(1) << CNT_W)) begin : g_chk
        $error("vfm_top: RETRY_STEP does not fit the retry counter");
    end

    logic scl_s;
    logic sda_s;

    vfm_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .pin_in(scl_in),
        .pin_sync(scl_s)
    );

    vfm_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .pin_in(sda_in),
        .pin_sync(sda_s)
    );

    // Bus engine state
    vfm_bus_t bst_r, bst_nxt;
    logic scl_q_r, scl_q_nxt;
    logic sda_q_r, sda_q_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [2:0] byte_cnt_r, byte_cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [1:0] tx_idx_r, tx_idx_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] wlo_r, wlo_nxt;
    logic [7:0] whi_r, whi_nxt;
    logic rd_r, rd_nxt;
    logic addressed_r, addressed_nxt;
    logic tack_ok_r, tack_ok_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic wr_commit, clr_req;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;

    // Register and status state
    vfm_thr_t thr_r, thr_nxt;
    logic [7:0] resp_r, resp_nxt;
    logic [7:0] sv_r, sv_nxt;
    logic alert_r, alert_nxt;
    logic [15:0] wdata;
    logic [15:0] status_word;
    logic ov_fault_det, ov_warn_det, uv_fault_det, uv_warn_det, uv_mask;

    // Run control state
    vfm_run_t run_r, run_nxt;
    logic drive_r, drive_nxt;
    logic off_req, retry_mode, tmr_load, tmr_expired, below_warn;
    logic [CNT_W-1:0] retry_load;

    assign scl_rise = scl_s & ~scl_q_r;
    assign scl_fall = ~scl_s & scl_q_r;
    assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign bus_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign wdata = {whi_r, wlo_r};

    always_comb begin
        status_word = 16'h0000;
        status_word[SW_VOUT_BIT] = |sv_r;
        status_word[SW_OV_FAULT_BIT] = sv_r[SV_OV_FAULT_BIT];
        case (cmd_r)
            CMD_OV_FAULT_THR: rd_word = thr_r.ov_fault;
            CMD_OV_FAULT_RESP: rd_word = {8'h00, resp_r};
            CMD_OV_WARN_THR: rd_word = thr_r.ov_warn;
            CMD_UV_WARN_THR: rd_word = thr_r.uv_warn;
            CMD_UV_FAULT_THR: rd_word = thr_r.uv_fault;
            CMD_STATUS_WORD: rd_word = status_word;
            CMD_STATUS_VOUT: rd_word = {8'h00, sv_r};
            default: rd_word = 16'h0000;
        endcase
        case (tx_idx_r)
            2'h0: rd_byte = rd_word[7:0];
            2'h1: rd_byte = rd_word[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // Byte engine; start and stop override any bit in progress
    always_comb begin
        bst_nxt = bst_r;
        scl_q_nxt = scl_s;
        sda_q_nxt = sda_s;
        bit_cnt_nxt = bit_cnt_r;
        byte_cnt_nxt = byte_cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        tx_idx_nxt = tx_idx_r;
        cmd_nxt = cmd_r;
        wlo_nxt = wlo_r;
        whi_nxt = whi_r;
        rd_nxt = rd_r;
        addressed_nxt = addressed_r;
        tack_ok_nxt = tack_ok_r;
        sda_oe_nxt = sda_oe_r;
        wr_commit = 1'b0;
        clr_req = 1'b0;
        if (bus_stop) begin
            bst_nxt = BUS_IDLE;
            sda_oe_nxt = 1'b0;
            addressed_nxt = 1'b0;
            if (addressed_r && !rd_r) begin
                wr_commit = 1'b1;
                clr_req = (byte_cnt_r == CNT_CMD_ONLY) && (cmd_r == CMD_CLEAR_FAULTS);
            end
        end else if (bus_start) begin
            bst_nxt = BUS_RX;
            bit_cnt_nxt = 4'h0;
            byte_cnt_nxt = 3'h0;
            sda_oe_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end else begin
            case (bst_r)
                BUS_RX: begin
                    if (scl_rise && bit_cnt_r != BYTE_BITS) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
                        bit_cnt_nxt = 4'h0;
                        if (byte_cnt_r != CNT_SAT) begin
                            byte_cnt_nxt = byte_cnt_r + 3'h1;
                        end
                        bst_nxt = BUS_RACK;
                        sda_oe_nxt = 1'b1;
                        case (byte_cnt_r)
                            3'h0: begin
                                if (sh_r[7:1] == DEV_ADDR) begin
                                    addressed_nxt = 1'b1;
                                    rd_nxt = sh_r[0];
                                    tx_idx_nxt = 2'h0;
                                end else begin
                                    bst_nxt = BUS_IDLE;
                                    sda_oe_nxt = 1'b0;
                                end
                            end
                            3'h1: cmd_nxt = sh_r;
                            3'h2: wlo_nxt = sh_r;
                            3'h3: whi_nxt = sh_r;
                            default: ;
                        endcase
                    end
                end
                BUS_RACK, BUS_TACK: begin
                    if (bst_r == BUS_TACK && scl_rise) begin
                        tack_ok_nxt = ~sda_s;
                    end else if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        bst_nxt = BUS_RX;
                        bit_cnt_nxt = 4'h0;
                        if (bst_r == BUS_TACK && !tack_ok_r) begin
                            bst_nxt = BUS_IDLE;
                        end else if (rd_r) begin
                            tx_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            bst_nxt = BUS_TX;
                            if (tx_idx_r != 2'h3) begin
                                tx_idx_nxt = tx_idx_r + 2'h1;
                            end
                        end
                    end
                end
                BUS_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == TX_LAST_BIT) begin
                            sda_oe_nxt = 1'b0;
                            tack_ok_nxt = 1'b0;
                            bst_nxt = BUS_TACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            sda_oe_nxt = ~tx_r[6];
                            bit_cnt_nxt = bit_cnt_r + 4'h1;
                        end
                    end
                end
                default: bst_nxt = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bst_r <= BUS_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 3'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            tx_idx_r <= 2'h0;
            cmd_r <= 8'h00;
            wlo_r <= 8'h00;
            whi_r <= 8'h00;
            rd_r <= 1'b0;
            addressed_r <= 1'b0;
            tack_ok_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (ce) begin
            bst_r <= bst_nxt;
            scl_q_r <= scl_q_nxt;
            sda_q_r <= sda_q_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            tx_idx_r <= tx_idx_nxt;
            cmd_r <= cmd_nxt;
            wlo_r <= wlo_nxt;
            whi_r <= whi_nxt;
            rd_r <= rd_nxt;
            addressed_r <= addressed_nxt;
            tack_ok_r <= tack_ok_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // Registers, detection and sticky status; a write needs its exact byte count
    always_comb begin
        thr_nxt = thr_r;
        resp_nxt = resp_r;
        if (wr_commit) begin
            case (cmd_r)
                CMD_OV_FAULT_RESP: begin
                    if (byte_cnt_r == CNT_ONE_DATA) begin
                        resp_nxt = wlo_r;
                    end
                end
                CMD_OV_FAULT_THR: begin
                    if (byte_cnt_r == CNT_TWO_DATA && wdata <= OV_FAULT_MAX) begin
                        thr_nxt.ov_fault = wdata;
                    end
                end
                CMD_OV_WARN_THR: begin
                    if (byte_cnt_r == CNT_TWO_DATA && wdata <= THR_MAX) begin
                        thr_nxt.ov_warn = wdata;
                    end
                end
                CMD_UV_WARN_THR: begin
                    if (byte_cnt_r == CNT_TWO_DATA && wdata <= THR_MAX) begin
                        thr_nxt.uv_warn = wdata;
                    end
                end
                CMD_UV_FAULT_THR: begin
                    if (byte_cnt_r == CNT_TWO_DATA && wdata <= THR_MAX) begin
                        thr_nxt.uv_fault = wdata;
                    end
                end
                default: ;
            endcase
        end
        // Unsigned compares on the same 2^-13 V scale as the sample
        ov_fault_det = sense.valid && (sense.vout > thr_r.ov_fault);
        // Only samples that land above the level count, so a fast edge can miss it
        ov_warn_det = sense.valid && (sense.vout > thr_r.ov_warn);
        uv_mask = sense.ramping | ~sense.power_good | ~drive_r;
        uv_fault_det = sense.valid && !uv_mask && (sense.vout < thr_r.uv_fault);
        uv_warn_det = sense.valid && !uv_mask && (sense.vout < thr_r.uv_warn);
        // Clear first, then sets, so a same-cycle event survives
        sv_nxt = clr_req ? 8'h00 : sv_r;
        sv_nxt[SV_OV_FAULT_BIT] = sv_nxt[SV_OV_FAULT_BIT] | ov_fault_det;
        sv_nxt[SV_OV_WARN_BIT] = sv_nxt[SV_OV_WARN_BIT] | ov_warn_det;
        sv_nxt[SV_UV_WARN_BIT] = sv_nxt[SV_UV_WARN_BIT] | uv_warn_det;
        sv_nxt[SV_UV_FAULT_BIT] = sv_nxt[SV_UV_FAULT_BIT] | uv_fault_det;
        alert_nxt = |sv_nxt;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            thr_r <= '{OV_FAULT_RST, OV_WARN_RST, UV_WARN_RST, UV_FAULT_RST};
            resp_r <= OV_RESP_RST;
            sv_r <= 8'h00;
            alert_r <= 1'b0;
        end else if (ce) begin
            thr_r <= thr_nxt;
            resp_r <= resp_nxt;
            sv_r <= sv_nxt;
            alert_r <= alert_nxt;
        end
    end

    // Overvoltage response and restart sequencing
    assign retry_load = CNT_W'(
        (int'(resp_r[RESP_DELAY_HI:RESP_DELAY_LO]) + 1) * RETRY_STEP);

    vfm_retry_timer #(.CNT_W(CNT_W)) u_retry_timer (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .load(tmr_load),
        .load_count(retry_load),
        .expired(tmr_expired)
    );

    always_comb begin
        off_req = ~ctrl.enable_cmd | ~ctrl.bias_ok | ctrl.other_shutdown;
        retry_mode = (resp_r[RESP_BEHAV_HI:RESP_BEHAV_LO] == BEHAV_DISABLE_RETRY) &&
            (resp_r[RESP_RETRY_HI:RESP_RETRY_LO] != RETRY_NONE);
        // Relies on the warning level sitting under the fault level
        below_warn = sense.valid && (sense.vout < thr_r.ov_warn);
        run_nxt = run_r;
        tmr_load = 1'b0;
        case (run_r)
            RUN_OFF: begin
                if (!off_req) begin
                    run_nxt = RUN_ON;
                end
            end
            RUN_ON: begin
                if (off_req) begin
                    run_nxt = RUN_OFF;
                end else if (ov_fault_det) begin
                    tmr_load = retry_mode;
                    run_nxt = retry_mode ? RUN_WAIT : RUN_LATCH;
                end
            end
            RUN_WAIT: begin
                if (off_req) begin
                    run_nxt = RUN_OFF;
                end else if (tmr_expired && below_warn) begin
                    run_nxt = RUN_ON;
                end
            end
            RUN_LATCH: begin
                // Latched off until faults are cleared or the output is cycled
                if (off_req || clr_req) begin
                    run_nxt = RUN_OFF;
                end
            end
            default: run_nxt = RUN_OFF;
        endcase
        drive_nxt = (run_nxt == RUN_ON);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r <= RUN_OFF;
            drive_r <= 1'b0;
        end else if (ce) begin
            run_r <= run_nxt;
            drive_r <= drive_nxt;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign alert_request_line_out = 1'b0;
    assign alert_request_line_oe = alert_r;
    assign output_drive_en = drive_r;
endmodule

/* File: vfm_checker.sv */
// Port assertions for vfm_top
module vfm_checker
    import vfm_pkg::*;
#(
    parameter int RETRY_STEP = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic alert_request_line_out,
    input wire logic alert_request_line_oe,
    input wire vfm_pkg::vfm_sense_t sense,
    input wire vfm_pkg::vfm_ctrl_t ctrl,
    input wire logic output_drive_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic off_req;
    logic [31:0] gap_r;
    assign off_req = !ctrl.enable_cmd | !ctrl.bias_ok | ctrl.other_shutdown;
    // Cycles the output has been off
    always_ff @(posedge clk) begin
        gap_r <= (!rst_b || output_drive_en) ? 32'h0 : gap_r + 32'h1;
    end
    property p_rst_quiet;
        @(posedge clk) !rst_b |=> !output_drive_en && !sda_oe && !alert_request_line_oe;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("active in reset");
    property p_off;
        @(posedge clk) disable iff (!rst_b) off_req |=> !output_drive_en;
    endproperty
    a_off: assert property (p_off)
        else $error("on while off");
    property p_over_max;
        @(posedge clk) disable iff (!rst_b)
        sense.valid && sense.vout > 16'hc000 |=> !output_drive_en && alert_request_line_oe;
    endproperty
    a_over_max: assert property (p_over_max)
        else $error("no fault response");
    property p_fall_alert;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $fell(output_drive_en) && !$past(off_req) |-> alert_request_line_oe;
    endproperty
    a_fall_alert: assert property (p_fall_alert)
        else $error("drop without alert");
    property p_retry_gap;
        @(posedge clk) disable iff (!rst_b)
        $rose(output_drive_en) && alert_request_line_oe |-> gap_r >= RETRY_STEP;
    endproperty
    a_retry_gap: assert property (p_retry_gap)
        else $error("restart too early");
    property p_open_drain;
        @(posedge clk) disable iff (!rst_b) !sda_out && !alert_request_line_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("pin driven high");
    property p_sda_timing;
        @(posedge clk) disable iff (!rst_b) $changed(sda_oe) |-> !scl_in && $past(!scl_in, 2);
    endproperty
    a_sda_timing: assert property (p_sda_timing)
        else $error("data moved with clock high");
    property p_alert_cause;
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $rose(alert_request_line_oe) |-> $past(sense.valid);
    endproperty
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert unsourced");
endmodule

/* File: vfm_host.sv */
// Bus host model for register transfers
module vfm_host #(
    parameter logic [6:0] DEV_ADDR = 7'h20
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    output logic nak
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        nak = 1'b0;
    end
    task automatic ph(input logic lo, input logic c, input int n);
        sda_low = lo;
        scl = c;
        repeat (n) @(negedge clk);
    endtask
    // Data moves after the clock fall, never a false start
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph(!d[i], 1'b0, 6);
            ph(!d[i], 1'b1, 8);
            q[i] = sda;
            ph(!d[i], 1'b0, 2);
        end
    endtask
    task automatic start;
        ph(1'b0, scl, 8);
        ph(1'b0, 1'b1, 8);
        ph(1'b1, 1'b1, 8);
        ph(1'b1, 1'b0, 2);
    endtask
    task automatic put(input logic [7:0] d);
        logic [8:0] q;
        xfer({d, 1'b1}, q);
        nak = nak | q[0];
    endtask
    // Words go low byte first
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int nb);
        start();
        put({DEV_ADDR, 1'b0});
        put(cmd);
        if (nb > 0) put(d[7:0]);
        if (nb > 1) put(d[15:8]);
        ph(1'b1, 1'b0, 8);
        ph(1'b1, 1'b1, 8);
        ph(1'b0, 1'b1, 8);
    endtask
    task automatic rd(input logic [7:0] cmd, input int nb, output logic [15:0] v);
        logic [8:0] q;
        start();
        put({DEV_ADDR, 1'b0});
        put(cmd);
        start();
        put({DEV_ADDR, 1'b1});
        xfer({8'hff, nb == 1}, q);
        v = {8'h00, q[8:1]};
        if (nb > 1) begin
            xfer(9'h1ff, q);
            v[15:8] = q[8:1];
        end
        ph(1'b1, 1'b0, 8);
        ph(1'b1, 1'b1, 8);
        ph(1'b0, 1'b1, 8);
    endtask
endmodule

/* File: tb_top.sv */
// Bench for vfm_top
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import vfm_pkg::*;
    localparam int RS = 20;
    logic clk;
    logic rst_b = 1'b0;
    vfm_sense_t sense = '{16'h2000, 1'b1, 1'b0, 1'b0};
    vfm_ctrl_t ctrl = '{1'b1, 1'b1, 1'b0};
    logic scl;
    logic sda_low;
    logic sda_oe;
    logic alert_oe;
    logic drv;
    logic nak;
    logic [15:0] v;
    int error_cnt = 0;
    int n_checks = 0;
    int k;
    logic [7:0] cmds [6] = '{CMD_OV_FAULT_THR, CMD_OV_FAULT_RESP, CMD_OV_WARN_THR,
        CMD_UV_WARN_THR, CMD_UV_FAULT_THR, 8'h50};
    logic [15:0] rsts [6] = '{OV_FAULT_RST, 16'h00b8, OV_WARN_RST, UV_WARN_RST,
        UV_FAULT_RST, 16'h0000};
    wire sda = !(sda_low | sda_oe);
    vfm_top #(.RETRY_STEP(RS)) vfm_top_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .alert_request_line_out(),
        .alert_request_line_oe(alert_oe), .sense(sense), .ctrl(ctrl), .output_drive_en(drv));
    vfm_host vfm_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .nak(nak));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One sample over any limit
    task automatic ov_pulse;
        sense.vout = 16'hc100;
        cyc(1);
        sense.vout = 16'h2000;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Over six times the run
    initial begin
        #900000;
        error_cnt++;
        summarize();
    end
    initial begin
        cyc(12);
        rst_b = 1'b1;
        cyc(4);
        foreach (cmds[i]) begin
            vfm_host_i.rd(cmds[i], 2, v);
            chk("reset", v, rsts[i]);
        end
        vfm_host_i.wr(CMD_OV_FAULT_THR, 16'hc000, 2);
        vfm_host_i.wr(CMD_OV_FAULT_THR, 16'hc001, 2);
        vfm_host_i.rd(CMD_OV_FAULT_THR, 2, v);
        chk("ov limit", v, 16'hc000);
        vfm_host_i.wr(CMD_OV_WARN_THR, 16'hb001, 2);
        vfm_host_i.rd(CMD_OV_WARN_THR, 2, v);
        chk("ov warn limit", v, OV_WARN_RST);
        $display("Test registers done");
        sense.vout = 16'h3000;
        cyc(4);
        sense.vout = 16'h2000;
        chk("warn alert", alert_oe, 1'b1);
        vfm_host_i.rd(CMD_STATUS_VOUT, 1, v);
        chk("vout status", v, 16'h0040);
        vfm_host_i.rd(CMD_STATUS_WORD, 2, v);
        chk("status word", v, 16'h8000);
        vfm_host_i.wr(CMD_CLEAR_FAULTS, 16'h0, 0);
        chk("cleared", alert_oe, 1'b0);
        $display("Test warning done");
        sense.vout = 16'hc100;
        cyc(100);
        chk("held off", drv, 1'b0);
        vfm_host_i.rd(CMD_STATUS_VOUT, 1, v);
        chk("fault bit", v & 16'h0080, 16'h0080);
        vfm_host_i.rd(CMD_STATUS_WORD, 2, v);
        chk("fault word", v, 16'h8020);
        sense.vout = 16'h2000;
        cyc(3);
        chk("restart", drv, 1'b1);
        vfm_host_i.wr(CMD_OV_FAULT_RESP, 16'h00bb, 1);
        ov_pulse();
        k = 0;
        while (!drv && k < 400) begin
            cyc(1);
            k++;
        end
        chk("retry gap", k >= 4 * RS && k <= 4 * RS + 2, 1'b1);
        ov_pulse();
        ctrl.enable_cmd = 1'b0;
        cyc(120);
        chk("cmd off", drv, 1'b0);
        ctrl.enable_cmd = 1'b1;
        cyc(4);
        chk("on again", drv, 1'b1);
        vfm_host_i.wr(CMD_OV_FAULT_RESP, 16'h0080, 1);
        ov_pulse();
        cyc(200);
        chk("latched", drv, 1'b0);
        vfm_host_i.wr(CMD_CLEAR_FAULTS, 16'h0, 0);
        chk("unlatched", drv, 1'b1);
        $display("Test overvoltage done");
        sense.power_good = 1'b1;
        sense.ramping = 1'b1;
        sense.vout = 16'h0800;
        cyc(10);
        chk("uv masked", alert_oe, 1'b0);
        sense.ramping = 1'b0;
        cyc(3);
        sense.vout = 16'h2000;
        vfm_host_i.rd(CMD_STATUS_VOUT, 1, v);
        chk("uv status", v, 16'h0030);
        chk("acks", nak, 1'b0);
        $display("Test undervoltage done");
        summarize();
    end
endmodule
bind vfm_top vfm_checker #(.RETRY_STEP(RETRY_STEP)) vfm_checker_i (.clk(clk), .rst_b(rst_b),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_request_line_out(alert_request_line_out),
    .alert_request_line_oe(alert_request_line_oe), .sense(sense), .ctrl(ctrl),
    .output_drive_en(output_drive_en));
